// >>> rtl/uart_cfg.svh
// Purpose: register map, field positions, reset values and timing for the serial port
// Assumes: APB byte addressing of word-aligned registers, 25 MHz core clock
// Notes: the offsets, reset values, baud timing and interrupt causes the logic uses are named here; the divisor floor of 2 is not
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define UART_OFS_DATA 8'h00
`define UART_OFS_CTRL 8'h04
`define UART_OFS_DIV 8'h08
`define UART_OFS_STAT 8'h0C
`define UART_OFS_ISTAT 8'h10
`define UART_OFS_IMASK 8'h14

// ==========================================================
// control fields and reset values
`define UART_CTRL_W 9
`define UART_CTRL_RST 9'h183
`define UART_LEN_BASE 4'h5
`define UART_PAR_NONE 2'h0
`define UART_PAR_ODD 2'h1
`define UART_STOP_1 2'h0
`define UART_STOP_1H 2'h1
`define UART_STAT_W 5

// ==========================================================
// baud timing
`define UART_CLK_HZ 25000000
`define UART_BAUD_DEF 115200
`define UART_DIV_DEF ((`UART_CLK_HZ + `UART_BAUD_DEF / 2) / `UART_BAUD_DEF)
`define UART_TMO_BITS 6'h20

// ==========================================================
// interrupt causes
`define UART_NUM_IRQ 10
`define UART_IRQ_RXRDY 0
`define UART_IRQ_TXEMPTY 1
`define UART_IRQ_TXDONE 2
`define UART_IRQ_PERR 3
`define UART_IRQ_FERR 4
`define UART_IRQ_OVR 5
`define UART_IRQ_BRK 6
`define UART_IRQ_CTS 7
`define UART_IRQ_TMO 8
`define UART_IRQ_TXOVF 9

`endif

// >>> rtl/uart_pkg.sv
// Purpose: shared types of the serial port
// Assumes: constants come from uart_cfg.svh
// Notes: ctrl_s bit order matches the control register layout
`default_nettype none
package uart_pkg;

  // ==========================================================
  // serializer states, gray coded along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_DATA = 3'h3,
    S_PAR = 3'h2,
    S_STOP = 3'h6
  } ser_e;

  // ==========================================================
  // character format and enables
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic flow_en;
    logic [1:0] parity;
    logic [1:0] stop;
    logic [1:0] len;
  } ctrl_s;

  // ==========================================================
  // apb slave signals
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage

`default_nettype wire

// >>> rtl/uart_core.sv
// Purpose: full-duplex asynchronous serial port with rts/cts flow control and apb registers
// Assumes: all inputs synchronous to clock; clk_en low freezes every flop
// Notes: no wait states on any apb access; single-word holding buffer per direction
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "uart_cfg.svh"
`default_nettype none

module uart_core #(
  parameter int DW = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire uart_pkg::apb_req_s apb_req,
  output uart_pkg::apb_rsp_s apb_rsp,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    uart_pkg::ctrl_s ctrl;
    logic [DW-1:0] div;
    logic [`UART_NUM_IRQ-1:0] istat;
    logic [`UART_NUM_IRQ-1:0] imask;
    logic [31:0] prdata;
    logic slverr;
    uart_pkg::ser_e tx_st;
    logic [DW:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [7:0] tx_shift;
    logic [7:0] tx_hold;
    logic tx_full;
    logic tx_par;
    logic tx_line;
    uart_pkg::ser_e rx_st;
    logic [DW:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_full;
    logic rx_armed;
    logic cts_q;
    logic [DW-1:0] tmo_cnt;
    logic [5:0] tmo_bits;
    logic tmo_done;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // ==========================================================
  // helpers
  function automatic logic [3:0] char_bits(input logic [1:0] len);
    char_bits = `UART_LEN_BASE + {2'h0, len};
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
                                   input logic [1:0] mode);
    logic [7:0] m;
    m = 8'hFF >> (4'h8 - char_bits(len));
    par_bit = (^(d & m)) ^ (mode == `UART_PAR_ODD);
  endfunction

  function automatic logic [DW:0] stop_len(input logic [1:0] stop, input logic [DW-1:0] div);
    logic [DW:0] d;
    d = {1'b0, div};
    if (stop == `UART_STOP_1) begin
      stop_len = d - 1'b1;
    end else if (stop == `UART_STOP_1H) begin
      stop_len = d + (d >> 1) - 1'b1;
    end else begin
      stop_len = (d << 1) - 1'b1;
    end
  endfunction

  logic setup;
  logic access;
  logic [7:0] addr;
  logic [DW:0] bit_len;
  logic [DW:0] half_len;
  logic tx_take;

  always_comb begin
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    addr = apb_req.paddr;
    bit_len = {1'b0, s_r.div} - 1'b1;
    // start cell checked near its middle, which still holds at the minimum divisor of two
    half_len = {2'b00, s_r.div[DW-1:1]} - 1'b1;
    // one decision shared by bus side and serializer, so no word is lost or sent twice
    tx_take = (s_r.tx_st == uart_pkg::S_IDLE) && s_r.tx_full && s_r.ctrl.tx_en
              && !(s_r.ctrl.flow_en && cts_n);
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;

    // ----- register bus: read data and error latched in the setup cycle
    if (setup) begin
      s_nxt.slverr = (addr[1:0] != 2'h0) || (addr > `UART_OFS_IMASK);
      s_nxt.prdata = 32'h0;
      unique case (addr)
        `UART_OFS_DATA: s_nxt.prdata = {24'h0, s_r.rx_data};
        `UART_OFS_CTRL: s_nxt.prdata = {23'h0, s_r.ctrl};
        `UART_OFS_DIV: s_nxt.prdata = 32'(s_r.div);
        `UART_OFS_STAT: s_nxt.prdata = {27'h0, cts_n, rts_n, s_r.rx_full, s_r.tx_full,
                                        s_r.tx_st != uart_pkg::S_IDLE};
        `UART_OFS_ISTAT: s_nxt.prdata = 32'(s_r.istat);
        `UART_OFS_IMASK: s_nxt.prdata = 32'(s_r.imask);
        default: s_nxt.prdata = 32'h0;
      endcase
    end

    // ----- register bus: writes and read side effects take effect at the access edge
    if (access && !s_r.slverr) begin
      if (apb_req.pwrite) begin
        unique case (addr)
          `UART_OFS_DATA: begin
            // a word written as the serializer takes the old one is kept, not flagged
            if (s_r.tx_full && !tx_take) begin
              s_nxt.istat[`UART_IRQ_TXOVF] = 1'b1;
            end else begin
              s_nxt.tx_hold = apb_req.pwdata[7:0];
              s_nxt.tx_full = 1'b1;
            end
          end
          `UART_OFS_CTRL: s_nxt.ctrl = apb_req.pwdata[`UART_CTRL_W-1:0];
          `UART_OFS_DIV: s_nxt.div = (apb_req.pwdata[DW-1:0] < DW'(2)) ? DW'(2)
                                     : apb_req.pwdata[DW-1:0];
          // write-one-to-clear; events below are applied later so they win
          `UART_OFS_ISTAT: s_nxt.istat = s_r.istat & ~apb_req.pwdata[`UART_NUM_IRQ-1:0];
          `UART_OFS_IMASK: s_nxt.imask = apb_req.pwdata[`UART_NUM_IRQ-1:0];
          default: s_nxt.imask = s_r.imask;
        endcase
      end else if (addr == `UART_OFS_DATA) begin
        s_nxt.rx_full = 1'b0;
      end
    end

    // transmitter, runs independently of the receiver
    if (s_r.tx_cnt != '0) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
    end
    unique case (s_r.tx_st)
      uart_pkg::S_IDLE: begin
        s_nxt.tx_line = 1'b1;
        if (tx_take) begin
          s_nxt.tx_shift = s_r.tx_hold;
          s_nxt.tx_par = par_bit(s_r.tx_hold, s_r.ctrl.len, s_r.ctrl.parity);
          s_nxt.tx_full = s_nxt.tx_full & apb_req.pwrite & access & (addr == `UART_OFS_DATA);
          s_nxt.istat[`UART_IRQ_TXEMPTY] = 1'b1;
          s_nxt.tx_line = 1'b0;
          s_nxt.tx_cnt = bit_len;
          s_nxt.tx_st = uart_pkg::S_START;
        end
      end
      uart_pkg::S_START: begin
        if (s_r.tx_cnt == '0) begin
          s_nxt.tx_line = s_r.tx_shift[0];
          s_nxt.tx_shift = s_r.tx_shift >> 1;
          s_nxt.tx_bit = 4'h1;
          s_nxt.tx_cnt = bit_len;
          s_nxt.tx_st = uart_pkg::S_DATA;
        end
      end
      uart_pkg::S_DATA: begin
        if (s_r.tx_cnt == '0) begin
          s_nxt.tx_cnt = bit_len;
          if (s_r.tx_bit == char_bits(s_r.ctrl.len)) begin
            if (s_r.ctrl.parity != `UART_PAR_NONE) begin
              s_nxt.tx_line = s_r.tx_par;
              s_nxt.tx_st = uart_pkg::S_PAR;
            end else begin
              s_nxt.tx_line = 1'b1;
              s_nxt.tx_cnt = stop_len(s_r.ctrl.stop, s_r.div);
              s_nxt.tx_st = uart_pkg::S_STOP;
            end
          end else begin
            s_nxt.tx_line = s_r.tx_shift[0];
            s_nxt.tx_shift = s_r.tx_shift >> 1;
            s_nxt.tx_bit = s_r.tx_bit + 1'b1;
          end
        end
      end
      uart_pkg::S_PAR: begin
        if (s_r.tx_cnt == '0) begin
          s_nxt.tx_line = 1'b1;
          s_nxt.tx_cnt = stop_len(s_r.ctrl.stop, s_r.div);
          s_nxt.tx_st = uart_pkg::S_STOP;
        end
      end
      uart_pkg::S_STOP: begin
        if (s_r.tx_cnt == '0) begin
          s_nxt.istat[`UART_IRQ_TXDONE] = 1'b1;
          s_nxt.tx_st = uart_pkg::S_IDLE;
        end
      end
      default: s_nxt.tx_st = uart_pkg::S_IDLE;
    endcase

    // ----- receiver: samples each bit mid-cell
    if (s_r.rx_cnt != '0) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
    end
    if (rxd) begin
      s_nxt.rx_armed = 1'b1;
    end
    unique case (s_r.rx_st)
      uart_pkg::S_IDLE: begin
        // armed only after a high line, so a held break is not read as endless starts
        if (s_r.ctrl.rx_en && s_r.rx_armed && !rxd) begin
          s_nxt.rx_cnt = half_len;
          s_nxt.rx_st = uart_pkg::S_START;
        end
      end
      uart_pkg::S_START: begin
        if (s_r.rx_cnt == '0) begin
          s_nxt.rx_st = rxd ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
          s_nxt.rx_cnt = bit_len;
          s_nxt.rx_bit = 4'h0;
          s_nxt.rx_shift = 8'h00;
        end
      end
      uart_pkg::S_DATA: begin
        if (s_r.rx_cnt == '0) begin
          s_nxt.rx_shift[s_r.rx_bit[2:0]] = rxd;
          s_nxt.rx_bit = s_r.rx_bit + 1'b1;
          s_nxt.rx_cnt = bit_len;
          if (s_r.rx_bit + 1'b1 == char_bits(s_r.ctrl.len)) begin
            s_nxt.rx_st = (s_r.ctrl.parity != `UART_PAR_NONE) ? uart_pkg::S_PAR
                          : uart_pkg::S_STOP;
          end
        end
      end
      uart_pkg::S_PAR: begin
        if (s_r.rx_cnt == '0) begin
          if (rxd != par_bit(s_r.rx_shift, s_r.ctrl.len, s_r.ctrl.parity)) begin
            s_nxt.istat[`UART_IRQ_PERR] = 1'b1;
          end
          s_nxt.rx_cnt = bit_len;
          s_nxt.rx_st = uart_pkg::S_STOP;
        end
      end
      uart_pkg::S_STOP: begin
        // only the first stop cell is checked; extra stop time is just idle line
        if (s_r.rx_cnt == '0) begin
          if (!rxd) begin
            s_nxt.istat[`UART_IRQ_FERR] = 1'b1;
            s_nxt.rx_armed = 1'b0;
            if (s_r.rx_shift == 8'h00) begin
              s_nxt.istat[`UART_IRQ_BRK] = 1'b1;
            end
          end
          if (s_nxt.rx_full) begin
            s_nxt.istat[`UART_IRQ_OVR] = 1'b1;
          end else begin
            s_nxt.rx_data = s_r.rx_shift;
            s_nxt.rx_full = 1'b1;
            s_nxt.istat[`UART_IRQ_RXRDY] = 1'b1;
          end
          s_nxt.rx_st = uart_pkg::S_IDLE;
        end
      end
      default: s_nxt.rx_st = uart_pkg::S_IDLE;
    endcase

    // ----- receive timeout: a word waits and the line stays idle for a while
    if (!s_r.rx_full || s_r.rx_st != uart_pkg::S_IDLE) begin
      s_nxt.tmo_cnt = '0;
      s_nxt.tmo_bits = 6'h0;
      s_nxt.tmo_done = 1'b0;
    end else if (!s_r.tmo_done) begin
      s_nxt.tmo_cnt = s_r.tmo_cnt + 1'b1;
      if (s_r.tmo_cnt == s_r.div - 1'b1) begin
        s_nxt.tmo_cnt = '0;
        s_nxt.tmo_bits = s_r.tmo_bits + 1'b1;
      end
      if (s_r.tmo_bits == `UART_TMO_BITS) begin
        s_nxt.tmo_done = 1'b1;
        s_nxt.istat[`UART_IRQ_TMO] = 1'b1;
      end
    end

    // ----- clear-to-send change
    s_nxt.cts_q = cts_n;
    if (s_r.cts_q != cts_n) begin
      s_nxt.istat[`UART_IRQ_CTS] = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ctrl <= `UART_CTRL_RST;
      s_r.div <= DW'(`UART_DIV_DEF);
      s_r.tx_line <= 1'b1;
      s_r.cts_q <= 1'b1;
      s_r.tx_st <= uart_pkg::S_IDLE;
      s_r.rx_st <= uart_pkg::S_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    // not gated by clk_en: a write made while the core is frozen is answered but lost
    apb_rsp.pready = access;
    apb_rsp.pslverr = access & s_r.slverr;
    apb_rsp.prdata = s_r.prdata;
    txd = s_r.tx_line;
    // high (stop) while a word waits unread or the receiver is off
    rts_n = s_r.rx_full | ~s_r.ctrl.rx_en;
    irq = |(s_r.istat & s_r.imask);
  end

endmodule

`default_nettype wire

// >>> testbench/uart_core_assertions.sv
// Purpose: port checker for uart_core
// Assumes: ctrl, divisor and mask are shadowed from apb writes
// Notes: bound to every uart_core instance
`timescale 1ns/1ps
`include "uart_cfg.svh"
`default_nettype none
module uart_core_assertions #(
  parameter int DW = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire uart_pkg::apb_req_s apb_req,
  input wire uart_pkg::apb_rsp_s apb_rsp,
  input wire logic rxd,
  input wire logic txd,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic irq
);
  logic wr;
  logic [8:0] ctl_r;
  logic [DW-1:0] div_r;
  logic [9:0] msk_r;
  int hi_r;
  int lo_r;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
  // ====================
  // shadows, so the line checks know the programmed format
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_r <= `UART_CTRL_RST;
      div_r <= DW'(`UART_DIV_DEF);
      msk_r <= '0;
      hi_r <= 0;
      lo_r <= 0;
    end else begin
      if (wr && apb_req.paddr == `UART_OFS_CTRL) ctl_r <= apb_req.pwdata[8:0];
      if (wr && apb_req.paddr == `UART_OFS_DIV) div_r <= apb_req.pwdata[DW-1:0];
      if (wr && apb_req.paddr == `UART_OFS_IMASK) msk_r <= apb_req.pwdata[9:0];
      hi_r <= txd ? hi_r + 1 : 0;
      lo_r <= txd ? 0 : lo_r + 1;
    end
  end
  // ====================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  a_ready_access: assert property (s_setup ##1 s_access |-> apb_rsp.pready)
    else $error("pready low in access cycle");
  a_ready_idle: assert property (!apb_req.psel |-> !apb_rsp.pready)
    else $error("pready high without select");
  a_slverr_bad: assert property (apb_req.psel && apb_req.penable && (apb_req.paddr[1:0] != 0
    || apb_req.paddr > `UART_OFS_IMASK) |-> apb_rsp.pslverr)
    else $error("bad address not refused");
  a_slverr_good: assert property (apb_req.psel && apb_req.penable && apb_req.paddr[1:0] == 0
    && apb_req.paddr <= `UART_OFS_IMASK |-> !apb_rsp.pslverr)
    else $error("good address refused");
  a_reset_idle: assert property (rst_n && !$past(rst_n) |-> txd && !irq && !rts_n)
    else $error("wrong line state after reset");
  a_rts_rx_off: assert property (!ctl_r[8] |-> rts_n)
    else $error("rts granted with receiver off");
  a_irq_masked: assert property (msk_r == 0 |-> !irq)
    else $error("irq with all causes masked");
  a_cts_holds: assert property (ctl_r[6] && cts_n && txd && hi_r > 12 * div_r |=> txd)
    else $error("frame started while cts high");
  a_bit_multiple: assert property ($rose(txd) |-> lo_r >= div_r && lo_r % div_r == 0)
    else $error("low run not whole bit times");
endmodule
bind uart_core uart_core_assertions #(.DW(DW)) i_chk (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp), .rxd(rxd), .txd(txd),
  .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
`default_nettype wire

// >>> testbench/serial_peer.sv
// Purpose: far-side serial device model
// Assumes: caller enters tasks right after a rising edge
// Notes: line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clock,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n
);
  int cyc = 0;
  logic cts_blk = 1'b0;
  initial rxd = 1'b1;
  assign cts_n = cts_blk;
  always @(posedge clock) cyc <= cyc + 1;
  // ====================
  // send one frame toward the port, lsb first
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb,
    input int stc, input int dv, input logic obey);
    while (obey && rts_n) @(posedge clock);
    rxd <= 1'b0;
    repeat (dv) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (dv) @(posedge clock);
    end
    if (pen) begin
      rxd <= pb;
      repeat (dv) @(posedge clock);
    end
    rxd <= 1'b1;
    repeat (stc) @(posedge clock);
  endtask
  // ====================
  // take one frame from the port, mid-bit sampling
  task automatic recv(input int nb, input logic pen, input int dv, output logic [7:0] d,
    output logic p, output int t0);
    d = '0;
    p = 1'b0;
    // no limit of its own: the bench timeout ends a hang
    while (txd !== 1'b1) @(posedge clock);
    while (txd !== 1'b0) @(posedge clock);
    t0 = cyc;
    repeat (dv / 2) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      repeat (dv) @(posedge clock);
      d[i] = txd;
    end
    if (pen) begin
      repeat (dv) @(posedge clock);
      p = txd;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/uart_with_hw_flow_control_tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: divisor of 4 clocks per bit keeps frames short
// Notes: apb master tasks; serial_peer on the line side
`timescale 1ns/1ps
`include "uart_cfg.svh"
`default_nettype none
module uart_with_hw_flow_control_tb;
  localparam int DV = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  uart_pkg::apb_req_s apb_req = '0;
  uart_pkg::apb_rsp_s apb_rsp;
  logic rxd, txd, cts_n, rts_n, irq, err;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int bauds[3] = '{1200, 115200, 921600};
  always #20 clock = ~clock;
  uart_core i_dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
  serial_peer i_peer (.clock(clock), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));
  // ====================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock);
    while (apb_rsp.pready !== 1'b1) @(posedge clock);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ====================
  // main sequence
  initial begin
    logic [7:0] w, g, g2, mk;
    logic p, p2;
    int t1, t2, nb, sc, pm;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rc(`UART_OFS_CTRL, 32'h183);
    rc(`UART_OFS_DIV, 32'(`UART_DIV_DEF));
    rc(`UART_OFS_STAT, 32'h0);
    apb(1'b0, 8'h18, '0);
    chk("unmapped", err, 1'b1);
    apb(1'b0, 8'h02, '0);
    chk("misaligned", err, 1'b1);
    apb(1'b1, `UART_OFS_IMASK, 32'h3FF);
    rc(`UART_OFS_IMASK, 32'h3FF);
    apb(1'b1, `UART_OFS_IMASK, 32'h0);
    foreach (bauds[i]) begin
      sc = (`UART_CLK_HZ + bauds[i] / 2) / bauds[i];
      apb(1'b1, `UART_OFS_DIV, sc);
      rc(`UART_OFS_DIV, sc);
    end
    apb(1'b1, `UART_OFS_DIV, DV);
    // every length, parity and stop setting, two frames back to back
    for (int k = 0; k < 36; k++) begin
      nb = k / 9 + 5;
      pm = (k / 3) % 3;
      sc = (k % 3 == 0) ? DV : (k % 3 == 1) ? DV + DV / 2 : 2 * DV;
      w = 8'h96 ^ 8'(k);
      mk = 8'hFF >> (8 - nb);
      apb(1'b1, `UART_OFS_CTRL, 32'h180 | (pm << 4) | ((k % 3) << 2) | (k / 9));
      fork
        begin
          i_peer.recv(nb, pm != 0, DV, g, p, t1);
          i_peer.recv(nb, pm != 0, DV, g2, p2, t2);
        end
        begin
          apb(1'b1, `UART_OFS_DATA, {24'h0, w});
          apb(1'b1, `UART_OFS_DATA, {24'h0, ~w});
        end
      join
      chk("tx data", g, w & mk);
      chk("tx next", g2, ~w & mk);
      if (pm != 0) chk("tx parity", p, (pm == 1) ? ~^(w & mk) : ^(w & mk));
      // the serializer spends one idle cycle after stop before the next start bit
      chk("tx frame", t2 - t1, (1 + nb + (pm != 0)) * DV + sc + 1);
      repeat (4 * DV) @(posedge clock);
    end
    // receive while sending, then overrun
    apb(1'b1, `UART_OFS_CTRL, 32'h1C3);
    fork
      i_peer.send(8'h3C, 8, 1'b0, 1'b0, DV, DV, 1'b1);
      begin
        apb(1'b1, `UART_OFS_DATA, 32'hC3);
        i_peer.recv(8, 1'b0, DV, g, p, t1);
      end
    join
    // the sender returns one cycle after the word lands
    @(posedge clock);
    chk("rx rts", rts_n, 1'b1);
    chk("duplex", g, 8'hC3);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, `UART_OFS_IMASK, 32'h21);
    @(posedge clock);
    chk("irq on", irq, 1'b1);
    i_peer.send(8'h55, 8, 1'b0, 1'b0, DV, DV, 1'b0);
    apb(1'b0, `UART_OFS_ISTAT, '0);
    chk("overrun", rd & 32'h21, 32'h21);
    rc(`UART_OFS_DATA, 32'h3C);
    @(posedge clock);
    chk("rts back", rts_n, 1'b0);
    apb(1'b1, `UART_OFS_ISTAT, 32'h3FF);
    @(posedge clock);
    chk("irq clear", irq, 1'b0);
    apb(1'b1, `UART_OFS_CTRL, 32'h1A3);
    i_peer.send(8'h0F, 8, 1'b1, 1'b1, DV, DV, 1'b1);
    apb(1'b0, `UART_OFS_ISTAT, '0);
    chk("parity err", rd[3], 1'b1);
    apb(1'b0, `UART_OFS_DATA, '0);
    // cts held off: the word must wait
    apb(1'b1, `UART_OFS_CTRL, 32'h1C3);
    i_peer.cts_blk <= 1'b1;
    apb(1'b1, `UART_OFS_DATA, 32'h5A);
    repeat (40 * DV) @(posedge clock);
    chk("cts hold", txd, 1'b1);
    fork
      i_peer.recv(8, 1'b0, DV, g, p, t1);
      i_peer.cts_blk <= 1'b0;
    join
    chk("cts go", g, 8'h5A);
    apb(1'b1, `UART_OFS_CTRL, 32'h0C3);
    @(posedge clock);
    chk("rx off rts", rts_n, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
